// >>> core/mscr_pkg.sv
// Constants and carrier types for the module system controller reset block
// Behaviour
// (R1) jtag_target_select low routes JTAG to FPGA, high to the controller.
// (R2) power_good_out is low while power_enable_in is low or supplies invalid.
// (R3) power_enable_in low pulls the FPGA power-on reset line low.
// (R4) fpga_program_n held low until every module supply is stable.
// (R5) external_reset_n low places the FPGA in reset.
// (R6) power_enable_in gates reset only; never switches off supply converters.
// (R7) Two indicators; after configuration done, user design controls them.
// (R8) Baseboard keeps I/Os high impedance until power_good_out rises.
// (R9) Release FPGA reset only when supplies, enable and reset input all good.
package mscr_pkg;

  // Minimum time all release conditions must hold before reset is released
  localparam int unsigned RELEASE_HOLD_NS = 1000;
  localparam int unsigned CLOCK_PERIOD_NS = 20;
  localparam int unsigned RELEASE_HOLD_CYC =
    (RELEASE_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned HOLD_W = $clog2(RELEASE_HOLD_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST =
    HOLD_W'(RELEASE_HOLD_CYC - 1);

  // Heartbeat blink while waiting for configuration: 2**22 cycles, ~84 ms
  localparam int unsigned BLINK_W = 22;

  typedef enum logic [1:0] {
    mscr_hold,
    mscr_settle,
    mscr_run
  } mscr_state_e;

  // Asynchronous board-level inputs, sampled through synchronisers
  typedef struct packed {
    logic supplies_ok;
    logic power_enable_in;
    logic external_reset_n;
    logic jtag_target_select;
    logic config_done;
  } mscr_pins_s;

  localparam int unsigned PINS_W = $bits(mscr_pins_s);
  localparam logic [PINS_W-1:0] PINS_RESET = PINS_W'(5'h00);

  typedef struct packed {
    logic green;
    logic red;
  } mscr_leds_s;

endpackage

// >>> core/mscr_sync.sv
// Two-flop synchroniser bank for the board-level inputs
`timescale 1ns/1ns
`default_nettype none
module mscr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Reset value zero keeps every derived enable deasserted except jtag_to_fpga
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// >>> core/mscr_top.sv
// Reset and power sequencing core of the module system controller
`timescale 1ns/1ns
`default_nettype none
module mscr_top (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Baseboard side
  input  wire logic                 power_enable_in,
  input  wire logic                 external_reset_n,
  input  wire logic                 jtag_target_select,
  output logic                      power_good_out,
  // Module supply monitor and FPGA status
  input  wire logic                 supplies_ok,
  input  wire logic                 config_done,
  // FPGA reset pins
  output logic                      fpga_program_n,
  output logic                      fpga_por_n,
  // JTAG routing
  output logic                      jtag_to_fpga,
  output logic                      jtag_to_controller,
  // Indicators
  input  wire mscr_pkg::mscr_leds_s user_leds,
  output logic                      green_indicator,
  output logic                      red_indicator
);
  import mscr_pkg::*;

  // Divider width: the blink phase toggles once per full count
  localparam int unsigned TICK_W = BLINK_W - 1;

  mscr_pins_s        pins_raw;
  mscr_pins_s        pins;
  mscr_state_e       state;
  mscr_state_e       next_state;
  logic [HOLD_W-1:0] hold_cnt;
  logic [TICK_W-1:0] blink_cnt;
  logic              blink_tick;
  logic              blink_phase;
  logic              in_run;
  logic              all_good;
  logic              cfg_seen;

  assign pins_raw = '{supplies_ok:        supplies_ok,
                      power_enable_in:    power_enable_in,
                      external_reset_n:   external_reset_n,
                      jtag_target_select: jtag_target_select,
                      config_done:        config_done};

  // Each pin crosses on its own; a one-cycle skew between them is
  // absorbed because release needs a long unbroken good window
  mscr_sync #(
    .WIDTH (PINS_W)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // Release condition

  // Enable only steers reset; no supply control output exists at all (R6)
  assign all_good = pins.supplies_ok & pins.power_enable_in
                  & pins.external_reset_n; // R9

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Release waits for an unbroken run of good inputs, then holds run
  always_comb begin
    next_state = state;
    unique case (state)
      mscr_hold: begin
        if (all_good) begin
          next_state = mscr_settle;
        end
      end
      mscr_settle: begin
        if (!all_good) begin
          next_state = mscr_hold;
        end else if (hold_cnt == HOLD_LAST) begin
          next_state = mscr_run;
        end
      end
      mscr_run: begin
        if (!all_good) begin
          next_state = mscr_hold; // R5
        end
      end
      // Unused code falls back to holding the FPGA in reset
      default: begin
        next_state = mscr_hold;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= mscr_hold;
    end else begin
      state <= next_state;
    end
  end

  // Conditions must stay good for the whole window; any glitch restarts it
  always_ff @(posedge clock) begin
    if (rst || state != mscr_settle) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + HOLD_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset and power-good outputs

  // Decoded once; the indicators and the handover flag share it
  assign in_run = (state == mscr_run);

  // Driven from next_state so release and state change share one edge
  always_ff @(posedge clock) begin
    if (rst) begin
      fpga_program_n <= 1'b0;
    end else begin
      // Held low through supply settle and any reset request
      fpga_program_n <= (next_state == mscr_run); // R4 R5 R9
    end
  end

  // Follows the enable pin alone, so a forced low imitates power-on
  always_ff @(posedge clock) begin
    if (rst) begin
      fpga_por_n <= 1'b0;
    end else begin
      fpga_por_n <= pins.power_enable_in; // R3
    end
  end

  // No settle window: the baseboard keys its own I/O release off this
  always_ff @(posedge clock) begin
    if (rst) begin
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= pins.power_enable_in & pins.supplies_ok; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // JTAG routing

  // Two flops from one source can never select both targets at once
  always_ff @(posedge clock) begin
    if (rst) begin
      jtag_to_fpga <= 1'b1;
    end else begin
      jtag_to_fpga <= ~pins.jtag_target_select; // R1
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      jtag_to_controller <= 1'b0;
    end else begin
      jtag_to_controller <= pins.jtag_target_select; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicators

  // Configuration-done seen only while the FPGA is running; lost on reset
  always_ff @(posedge clock) begin
    if (rst || !in_run) begin
      cfg_seen <= 1'b0;
    end else if (pins.config_done) begin
      cfg_seen <= 1'b1;
    end
  end

  // Divider gives a one-cycle tick; the blink phase toggles on it
  always_ff @(posedge clock) begin
    if (rst) begin
      blink_cnt <= '0;
    end else begin
      blink_cnt <= blink_cnt + TICK_W'(1);
    end
  end

  assign blink_tick = (blink_cnt == '1);

  always_ff @(posedge clock) begin
    if (rst) begin
      blink_phase <= 1'b0;
    end else if (blink_tick) begin
      blink_phase <= ~blink_phase;
    end
  end

  // Before handover: green blinks while awaiting configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      green_indicator <= 1'b0;
    end else if (cfg_seen) begin
      green_indicator <= user_leds.green; // R7
    end else begin
      green_indicator <= in_run & blink_phase;
    end
  end

  // Before handover: red stays lit for as long as the FPGA is held
  always_ff @(posedge clock) begin
    if (rst) begin
      red_indicator <= 1'b1;
    end else if (cfg_seen) begin
      red_indicator <= user_leds.red; // R7
    end else begin
      red_indicator <= ~in_run;
    end
  end

endmodule
`default_nettype wire

// >>> test/mscr_fpga_model.sv
// Far-side model: an FPGA that finishes configuring after release
`timescale 1ns/1ns
`default_nettype none
module mscr_fpga_model (
  // Clock
  input  wire logic clock,
  // Program line in, configuration status out
  input  wire logic fpga_program_n,
  output logic      config_done
);
  logic [3:0] cnt;
  // Configuration restarts whenever the program line is pulled low
  always_ff @(posedge clock) begin
    if (!fpga_program_n) cnt <= 4'h0;
    else if (cnt != 4'hf) cnt <= cnt + 4'h1;
  end
  assign config_done = (cnt == 4'hf);
endmodule
`default_nettype wire

// >>> test/mscr_top_properties.sv
// Port assertions for the sequencing core
`timescale 1ns/1ns
`default_nettype none
module mscr_top_chk (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Baseboard side
  input  wire logic                 power_enable_in,
  input  wire logic                 external_reset_n,
  input  wire logic                 jtag_target_select,
  input  wire logic                 power_good_out,
  // Module supply monitor and FPGA status
  input  wire logic                 supplies_ok,
  input  wire logic                 config_done,
  // FPGA reset pins
  input  wire logic                 fpga_program_n,
  input  wire logic                 fpga_por_n,
  // JTAG routing
  input  wire logic                 jtag_to_fpga,
  input  wire logic                 jtag_to_controller,
  // Indicators
  input  wire mscr_pkg::mscr_leds_s user_leds,
  input  wire logic                 green_indicator,
  input  wire logic                 red_indicator
);
  import mscr_pkg::*;
  localparam int REL = RELEASE_HOLD_CYC;
  logic [2:0] up;
  logic [6:0] gc;
  wire        ag = supplies_ok & power_enable_in & external_reset_n;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Settling time after reset so that three-deep history is valid
  always_ff @(posedge clock) begin
    if (rst) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  always_ff @(posedge clock) begin
    if (rst || !ag) gc <= 7'h00;
    else if (gc != 7'h7f) gc <= gc + 7'h01;
  end
  pg_low_a: assert property (!$past(power_enable_in, 3) ||
    !$past(supplies_ok, 3) |-> !power_good_out) else $error("pg high");
  pg_high_a: assert property (up > 3'h3 && $past(power_enable_in &
    supplies_ok, 3) |-> power_good_out) else $error("pg low");
  por_mirror_a: assert property (up > 3'h3 |->
    fpga_por_n == $past(power_enable_in, 3)) else $error("por wrong");
  prog_hold_a: assert property (!$past(ag, 3) |-> !fpga_program_n)
    else $error("fpga left out of reset");
  prog_early_a: assert property ($rose(fpga_program_n) |-> gc > REL)
    else $error("release too early");
  prog_late_a: assert property (gc == REL + 8 |-> fpga_program_n)
    else $error("release missing");
  jtag_route_a: assert property (up > 3'h3 |->
    jtag_to_controller == $past(jtag_target_select, 3) &&
    jtag_to_fpga == !$past(jtag_target_select, 3)) else $error("jtag");
  jtag_excl_a: assert property (jtag_to_fpga != jtag_to_controller)
    else $error("jtag both");
  led_user_a: assert property (fpga_program_n &&
    $past(fpga_program_n, 5) && $past(config_done, 4) |->
    {green_indicator, red_indicator} == $past(user_leds))
    else $error("leds not user driven");
endmodule
bind mscr_top mscr_top_chk chk (
  .clock              (clock),
  .rst                (rst),
  .power_enable_in    (power_enable_in),
  .external_reset_n   (external_reset_n),
  .jtag_target_select (jtag_target_select),
  .power_good_out     (power_good_out),
  .supplies_ok        (supplies_ok),
  .config_done        (config_done),
  .fpga_program_n     (fpga_program_n),
  .fpga_por_n         (fpga_por_n),
  .jtag_to_fpga       (jtag_to_fpga),
  .jtag_to_controller (jtag_to_controller),
  .user_leds          (user_leds),
  .green_indicator    (green_indicator),
  .red_indicator      (red_indicator)
);
`default_nettype wire

// >>> test/tb_mscr_top.sv
// Self-checking bench for the sequencing core
`timescale 1ns/1ns
`default_nettype none
module tb_mscr_top;
  import mscr_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       sup = 1'b0;
  logic       en = 1'b1;
  logic       resn = 1'b1;
  logic       sel = 1'b0;
  mscr_leds_s uled = 2'h0;
  logic       cdone, pg, prg, por, jf, jc, gr, rd;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         cyc = 0;
  mscr_top uut (.clock(clock), .rst(rst), .power_enable_in(en),
    .external_reset_n(resn), .jtag_target_select(sel),
    .power_good_out(pg), .supplies_ok(sup), .config_done(cdone),
    .fpga_program_n(prg), .fpga_por_n(por), .jtag_to_fpga(jf),
    .jtag_to_controller(jc), .user_leds(uled),
    .green_indicator(gr), .red_indicator(rd));
  mscr_fpga_model fpga (.clock(clock), .fpga_program_n(prg),
    .config_done(cdone));
  initial forever #10 clock = ~clock;
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic chk(input string nm, input logic s, input logic e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    sup = 1'b1;
    step(40);
    chk("prog", prg, 1'b0);
    chk("red", rd, 1'b1);
    chk("green", gr, 1'b0);
    step(20);
    chk("prog", prg, 1'b1);
    chk("pg", pg, 1'b1);
  endtask
  task automatic t_cause(input int k);
    // Supplies stay up while enable is low: enable gates reset only
    en = (k != 0);
    sup = (k != 1);
    resn = (k != 2);
    step(4);
    chk("prog", prg, 1'b0);
    chk("pg", pg, k == 2);
    chk("por", por, k != 0);
    {en, sup, resn} = 3'h7;
    step(60);
    chk("prog", prg, 1'b1);
  endtask
  task automatic t_jtag();
    sel = 1'b1;
    step(4);
    chk("jtag ctl", jc, 1'b1);
    chk("jtag fpga", jf, 1'b0);
    sel = 1'b0;
    step(4);
    chk("jtag fpga", jf, 1'b1);
    chk("jtag ctl", jc, 1'b0);
  endtask
  task automatic t_reset();
    // Mid-run reset returns every output to its safe level at once
    rst = 1'b1;
    step(3);
    chk("reset prog", prg, 1'b0);
    chk("reset por", por, 1'b0);
    chk("reset pg", pg, 1'b0);
    chk("reset jtag fpga", jf, 1'b1);
    chk("reset jtag ctl", jc, 1'b0);
    chk("reset green", gr, 1'b0);
    chk("reset red", rd, 1'b1);
    rst = 1'b0;
    step(2);
    chk("prog", prg, 1'b0);
    step(60);
    chk("prog", prg, 1'b1);
    chk("por", por, 1'b1);
    chk("pg", pg, 1'b1);
  endtask
  task automatic t_leds();
    step(30);
    uled = 2'h2;
    step(2);
    chk("green", gr, 1'b1);
    chk("red", rd, 1'b0);
    uled = 2'h1;
    step(2);
    chk("red", rd, 1'b1);
    chk("green", gr, 1'b0);
  endtask
  initial begin
    step(3);
    chk("reset prog", prg, 1'b0);
    chk("reset pg", pg, 1'b0);
    rst = 1'b0;
    t_boot();
    t_leds();
    for (int k = 0; k < 3; k++) t_cause(k);
    t_jtag();
    t_reset();
    close_out();
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      close_out();
    end
  end
endmodule
`default_nettype wire
